// >>> can_irq_pkg.sv
// Register map, field layout and reset values of the CAN interrupt router.
package can_irq_pkg;
	localparam int FLAG_COUNT = 30;
	localparam logic [7:0] FLAG_OFFSET = 8'h50;
	localparam logic [7:0] ENABLE_MASK_OFFSET = 8'h54;
	localparam logic [7:0] LINE_ROUTING_OFFSET = 8'h58;
	localparam logic [7:0] LINE_ENABLE_OFFSET = 8'h5c;
	localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h60;
	localparam logic [7:0] EVENT_CLEAR_OFFSET = 8'h64;
	localparam logic [7:0] EVENT_ENABLE_OFFSET = 8'h68;
	localparam logic [31:0] ENABLE_MASK_RESET = 32'h00000000;
	localparam logic [31:0] LINE_ROUTING_RESET = 32'h00000000;
	localparam logic [1:0] LINE_ENABLE_RESET = 2'h0;
	localparam logic [29:0] FLAG_RESET = 30'h00000000;
	localparam logic [1:0] EVENT_RESET = 2'h0;
	localparam int LINE_COUNT = 2;
	localparam int RESERVED_ACCESS_BIT = 29;
	localparam int EVENT_DROP_BIT = 0;
	localparam int EVENT_RESERVED_BIT = 1;
endpackage

// >>> flag_cell.sv
// One edge-sensitive status flag with write-one-to-clear.
`timescale 1ns/100ps
module flag_cell (
	input wire logic ref_clk, // Register clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic cond, // Condition level, same clock domain.
	input wire logic clr, // Software write of one to this bit.
	output logic flag // Sticky flag.
);
	logic cond_reg;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cond_reg <= 1'b0;
		end else begin
			cond_reg <= cond;
		end
	end

	// A rising edge in the same cycle as the clear keeps the flag set.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (cond && !cond_reg) begin
			flag <= 1'b1;
		end else if (clr) begin
			flag <= 1'b0;
		end
	end
endmodule

// >>> can_interrupt_enable_routing.sv
// Flag register, per-flag enable and line routing of the CAN interrupts.
//
// Notes on behaviour
// - Flag reaches a line only when enabled.
// - Enable bit zero blocks, one passes; reset zero.
// - Bits 29..24 gate reserved access through warning.
// - Bits 23..16 gate passive through timestamp wrap.
// - Bits 15..8 gate transmit event and transmit flags.
// - Bits 7..0 gate receive FIFO 1 then 0.
// - Line routing register selects line per flag.
// - Routing zero gives line 0, one line 1.
// - Routing bits share flag positions; 31:30 unused.
// - Flags set on edge, cleared by writing one.
// - Each line has its own master enable.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module can_interrupt_enable_routing #(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk, // Register clock, 20 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [29:0] flag_cond, // Flag condition levels.
	input wire logic [ADDR_W-1:0] reg_addr, // Register byte address.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [31:0] reg_rdata, // Read data, cycle after strobe.
	output logic [1:0] irq_line, // Module interrupt lines.
	output logic event_irq // Block-event interrupt level.
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [29:0] flag_q;
	logic [29:0] flag_clr;
	logic [31:0] enable_mask_reg;
	logic [31:0] line_routing_reg;
	logic [1:0] line_enable_reg;
	logic [1:0] event_status_reg;
	logic [1:0] event_enable_reg;
	logic [29:0] gated;
	logic [1:0] irq_next;
	logic [1:0] event_set;
	logic addr_known;

	assign flag_clr = (reg_wr && reg_addr == ADDR_W'(can_irq_pkg::FLAG_OFFSET))
		? reg_wdata[29:0] : 30'h00000000;

	genvar i;
	generate
		for (i = 0; i < can_irq_pkg::FLAG_COUNT; i++) begin : g_flag
			flag_cell u_cell (
				.ref_clk(ref_clk),
				.srst(srst),
				.cond(flag_cond[i]),
				.clr(flag_clr[i]),
				.flag(flag_q[i])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			enable_mask_reg <= can_irq_pkg::ENABLE_MASK_RESET;
		end else if (reg_wr &&
			reg_addr == ADDR_W'(can_irq_pkg::ENABLE_MASK_OFFSET)) begin
			// Bits 31:30 have no flag behind them and stay zero.
			enable_mask_reg <= {2'h0, reg_wdata[29:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			line_routing_reg <= can_irq_pkg::LINE_ROUTING_RESET;
		end else if (reg_wr &&
			reg_addr == ADDR_W'(can_irq_pkg::LINE_ROUTING_OFFSET)) begin
			line_routing_reg <= {2'h0, reg_wdata[29:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			line_enable_reg <= can_irq_pkg::LINE_ENABLE_RESET;
		end else if (reg_wr &&
			reg_addr == ADDR_W'(can_irq_pkg::LINE_ENABLE_OFFSET)) begin
			line_enable_reg <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Gating and routing
	// ----------------------------------------------------------------
	assign gated = flag_q & enable_mask_reg[29:0];

	always_comb begin
		irq_next[0] = line_enable_reg[0] &&
			|(gated & ~line_routing_reg[29:0]);
		irq_next[1] = line_enable_reg[1] &&
			|(gated & line_routing_reg[29:0]);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_line <= 2'h0;
		end else begin
			irq_line <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// Block events: unmapped access and an ignored write to flags.
	// ----------------------------------------------------------------
	always_comb begin
		addr_known = reg_addr == ADDR_W'(can_irq_pkg::FLAG_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::ENABLE_MASK_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::LINE_ROUTING_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::LINE_ENABLE_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::EVENT_STATUS_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::EVENT_CLEAR_OFFSET) ||
			reg_addr == ADDR_W'(can_irq_pkg::EVENT_ENABLE_OFFSET);
		event_set = 2'h0;
		event_set[can_irq_pkg::EVENT_RESERVED_BIT] =
			(reg_wr || reg_rd) && !addr_known;
		event_set[can_irq_pkg::EVENT_DROP_BIT] = flag_clr == 30'h00000000 &&
			reg_wr && reg_addr == ADDR_W'(can_irq_pkg::FLAG_OFFSET);
	end

	// Set wins over a clear in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_status_reg <= can_irq_pkg::EVENT_RESET;
		end else if (reg_wr &&
			reg_addr == ADDR_W'(can_irq_pkg::EVENT_CLEAR_OFFSET)) begin
			event_status_reg <= (event_status_reg & ~reg_wdata[1:0])
				| event_set;
		end else begin
			event_status_reg <= event_status_reg | event_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_enable_reg <= can_irq_pkg::EVENT_RESET;
		end else if (reg_wr &&
			reg_addr == ADDR_W'(can_irq_pkg::EVENT_ENABLE_OFFSET)) begin
			event_enable_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_irq <= 1'b0;
		end else begin
			event_irq <= |(event_status_reg & event_enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			unique case (reg_addr)
				ADDR_W'(can_irq_pkg::FLAG_OFFSET):
					reg_rdata <= {2'h0, flag_q};
				ADDR_W'(can_irq_pkg::ENABLE_MASK_OFFSET):
					reg_rdata <= enable_mask_reg;
				ADDR_W'(can_irq_pkg::LINE_ROUTING_OFFSET):
					reg_rdata <= line_routing_reg;
				ADDR_W'(can_irq_pkg::LINE_ENABLE_OFFSET):
					reg_rdata <= {30'h00000000, line_enable_reg};
				ADDR_W'(can_irq_pkg::EVENT_STATUS_OFFSET):
					reg_rdata <= {30'h00000000, event_status_reg};
				ADDR_W'(can_irq_pkg::EVENT_ENABLE_OFFSET):
					reg_rdata <= {30'h00000000, event_enable_reg};
				default:
					reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property gate_blocks;
		@(posedge ref_clk) disable iff (srst)
		(flag_q & enable_mask_reg[29:0]) == 30'h00000000
			|=> irq_line == 2'h0;
	endproperty
	gate_blocks_a: assert property (gate_blocks)
		else $error("Line raised with no enabled flag.");

	// Checked one edge after a sampled reset, so no history is needed.
	enable_reset_a: assert property (@(posedge ref_clk)
		srst |=> enable_mask_reg == 32'h00000000 &&
		line_routing_reg == 32'h00000000)
		else $error("Mask or routing not cleared by reset.");

	unused_bits_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		enable_mask_reg[31:30] == 2'h0 && line_routing_reg[31:30] == 2'h0)
		else $error("Unused high bits became set.");

	route_line1_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(line_enable_reg[1] && |(gated & line_routing_reg[29:0]))
		|=> irq_line[1])
		else $error("Line 1 missing for routed flag.");

	route_line0_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(line_enable_reg[0] && |(gated & ~line_routing_reg[29:0]))
		|=> irq_line[0])
		else $error("Line 0 missing for routed flag.");

	master_off_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!line_enable_reg[1] |=> !irq_line[1])
		else $error("Disabled line 1 asserted.");

	master_off0_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!line_enable_reg[0] |=> !irq_line[0])
		else $error("Disabled line 0 asserted.");

	line1_idle_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!(line_enable_reg[1] && |(gated & line_routing_reg[29:0]))
		|=> !irq_line[1])
		else $error("Line 1 high with no routed cause.");

	line0_idle_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!(line_enable_reg[0] && |(gated & ~line_routing_reg[29:0]))
		|=> !irq_line[0])
		else $error("Line 0 high with no routed cause.");

	sequence rise_seen;
		!flag_cond[0] ##1 flag_cond[0];
	endsequence
	flag_edge_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		rise_seen |=> flag_q[0])
		else $error("Flag not set by rising condition.");

	flag_clear_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(flag_clr[0] && !(flag_cond[0] && !g_flag[0].u_cell.cond_reg))
		|=> !flag_q[0])
		else $error("Write of one did not clear the flag.");

	level_hold_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(irq_line[0] && $stable(gated) && $stable(line_routing_reg) &&
		$stable(line_enable_reg)) |=> irq_line[0])
		else $error("Line 0 dropped while cause remained.");

	// Writes to the configuration words land at the next edge.
	sequence mask_write;
		reg_wr && reg_addr == ADDR_W'(can_irq_pkg::ENABLE_MASK_OFFSET);
	endsequence
	mask_write_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		mask_write |=> enable_mask_reg == ($past(reg_wdata) & 32'h3fffffff))
		else $error("Enable mask write lost.");

	sequence route_write;
		reg_wr && reg_addr == ADDR_W'(can_irq_pkg::LINE_ROUTING_OFFSET);
	endsequence
	route_write_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		route_write |=> line_routing_reg == ($past(reg_wdata) & 32'h3fffffff))
		else $error("Line routing write lost.");

	sequence line_en_write;
		reg_wr && reg_addr == ADDR_W'(can_irq_pkg::LINE_ENABLE_OFFSET);
	endsequence
	line_en_write_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		line_en_write |=> line_enable_reg == ($past(reg_wdata) & 32'h3))
		else $error("Line enable write lost.");

	// Read data stand for one cycle only and are zero otherwise.
	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		!reg_rd |=> reg_rdata == 32'h00000000)
		else $error("Read data present without a read.");

	sequence mask_read;
		reg_rd && reg_addr == ADDR_W'(can_irq_pkg::ENABLE_MASK_OFFSET);
	endsequence
	rdata_mask_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		mask_read |=> reg_rdata == $past(enable_mask_reg))
		else $error("Mask read returned a wrong word.");

	// An event in the same cycle as its clear must still be seen.
	event_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
		|event_set |=> (event_status_reg & $past(event_set)) ==
		$past(event_set))
		else $error("Block event lost.");

	event_irq_a: assert property (@(posedge ref_clk) disable iff (srst)
		|(event_status_reg & event_enable_reg) |=> event_irq)
		else $error("Block event interrupt missing.");

	// Every flag cell gets the same set and hold checks.
	genvar j;
	generate
		for (j = 0; j < can_irq_pkg::FLAG_COUNT; j++) begin : g_flag_chk
			sequence cond_rise;
				!flag_cond[j] ##1 flag_cond[j];
			endsequence
			flag_rise_a: assert property (
				@(posedge ref_clk) disable iff (srst)
				cond_rise |=> flag_q[j])
				else $error("Flag not set by its condition.");
			flag_hold_a: assert property (
				@(posedge ref_clk) disable iff (srst)
				flag_q[j] && !flag_clr[j] |=> flag_q[j])
				else $error("Flag dropped without a clear.");
		end
	endgenerate
endmodule

// >>> irq_sink.sv
// Behavioural model of the processor interrupt controller on both lines.
`timescale 1ns/100ps
module irq_sink (
	input wire logic ref_clk, // Register clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [1:0] irq_line, // Lines from the router.
	output logic [1:0] pending // Sticky record of each line seen high.
);
	// A level line may drop before software looks, so it is latched here.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pending <= 2'h0;
		end else begin
			pending <= pending | irq_line;
		end
	end
endmodule

// >>> can_interrupt_enable_routing_tb_top.sv
// Self-checking bench of the CAN interrupt enable and line routing.
`timescale 1ns/100ps
module can_interrupt_enable_routing_tb_top;
	typedef struct {
		logic [4:0] idx;
		logic [31:0] mask;
		logic [31:0] route;
		logic [31:0] line_en;
		logic [1:0] irq;
	} row_t;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [29:0] flag_cond = 30'h0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0] irq_line;
	logic event_irq;
	logic [1:0] pending;
	logic [31:0] d;
	int n_mismatch = 0;
	int comparisons = 0;
	row_t rows [8] = '{
		'{5'd29, 32'h20000000, 32'h0, 32'h3, 2'h1},
		'{5'd28, 32'h10000000, 32'h10000000, 32'h3, 2'h2},
		'{5'd24, 32'h0, 32'h0, 32'h3, 2'h0},
		'{5'd16, 32'h00010000, 32'h00010000, 32'h1, 2'h0},
		'{5'd15, 32'h00008000, 32'h0, 32'h2, 2'h0},
		'{5'd8, 32'h00000100, 32'h00000100, 32'h2, 2'h2},
		'{5'd7, 32'hffffffff, 32'hffffffff, 32'h3, 2'h2},
		'{5'd0, 32'hffffffff, 32'h0, 32'h3, 2'h1}
	};
	can_interrupt_enable_routing u_can_interrupt_enable_routing (
		.ref_clk(ref_clk), .srst(srst), .flag_cond(flag_cond),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_line(irq_line),
		.event_irq(event_irq)
	);
	irq_sink u_irq_sink (
		.ref_clk(ref_clk), .srst(srst), .irq_line(irq_line),
		.pending(pending)
	);
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic pulse(input logic [4:0] i);
		@(posedge ref_clk);
		flag_cond[i] <= 1'b1;
		@(posedge ref_clk);
		flag_cond[i] <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		n_mismatch++;
		summarize();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		rd(can_irq_pkg::ENABLE_MASK_OFFSET);
		chk("mask reset", d, can_irq_pkg::ENABLE_MASK_RESET);
		rd(can_irq_pkg::LINE_ROUTING_OFFSET);
		chk("route reset", d, can_irq_pkg::LINE_ROUTING_RESET);
		wr(can_irq_pkg::ENABLE_MASK_OFFSET, 32'hffffffff);
		rd(can_irq_pkg::ENABLE_MASK_OFFSET);
		chk("mask width", d, 32'h3fffffff);
		wr(can_irq_pkg::LINE_ROUTING_OFFSET, 32'hffffffff);
		rd(can_irq_pkg::LINE_ROUTING_OFFSET);
		chk("route width", d, 32'h3fffffff);
		foreach (rows[k]) begin
			wr(can_irq_pkg::ENABLE_MASK_OFFSET, rows[k].mask);
			wr(can_irq_pkg::LINE_ROUTING_OFFSET, rows[k].route);
			wr(can_irq_pkg::LINE_ENABLE_OFFSET, rows[k].line_en);
			pulse(rows[k].idx);
			chk("irq line", {30'h0, irq_line}, {30'h0, rows[k].irq});
			rd(can_irq_pkg::FLAG_OFFSET);
			chk("flag set", d, 32'h1 << rows[k].idx);
			wr(can_irq_pkg::FLAG_OFFSET, 32'h1 << rows[k].idx);
			repeat (2) @(posedge ref_clk);
			#1 chk("irq cleared", {30'h0, irq_line}, 32'h0);
		end
		// Mask change on a standing flag, and a write of zero to flags.
		wr(can_irq_pkg::ENABLE_MASK_OFFSET, 32'h0);
		wr(can_irq_pkg::LINE_ROUTING_OFFSET, 32'h0);
		pulse(5'd19);
		chk("masked", {30'h0, irq_line}, 32'h0);
		wr(can_irq_pkg::ENABLE_MASK_OFFSET, 32'h00080000);
		repeat (2) @(posedge ref_clk);
		#1 chk("unmasked", {30'h0, irq_line}, 32'h1);
		wr(can_irq_pkg::FLAG_OFFSET, 32'h0);
		rd(can_irq_pkg::FLAG_OFFSET);
		chk("write zero", d, 32'h00080000);
		// A clear and a new edge on one bit in the same cycle: set wins.
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= can_irq_pkg::FLAG_OFFSET;
		reg_wdata <= 32'h00000002;
		flag_cond[1] <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		flag_cond[1] <= 1'b0;
		rd(can_irq_pkg::FLAG_OFFSET);
		chk("set wins", d, 32'h00080002);
		chk("sink", {30'h0, pending}, 32'h3);
		// Unmapped access raises the block event interrupt.
		rd(8'h70);
		chk("unmapped", d, 32'h0);
		wr(can_irq_pkg::EVENT_ENABLE_OFFSET, 32'h3);
		rd(can_irq_pkg::EVENT_STATUS_OFFSET);
		chk("event", d, 32'h3);
		#1 chk("event irq", {31'h0, event_irq}, 32'h1);
		wr(can_irq_pkg::EVENT_ENABLE_OFFSET, 32'h0);
		repeat (2) @(posedge ref_clk);
		#1 chk("event masked", {31'h0, event_irq}, 32'h0);
		wr(can_irq_pkg::EVENT_CLEAR_OFFSET, 32'h3);
		rd(can_irq_pkg::EVENT_STATUS_OFFSET);
		chk("event clear", d, 32'h0);
		// Reset in mid-run returns every register and line to idle.
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		rd(can_irq_pkg::ENABLE_MASK_OFFSET);
		chk("mask rereset", d, can_irq_pkg::ENABLE_MASK_RESET);
		rd(can_irq_pkg::LINE_ENABLE_OFFSET);
		chk("line en reset", d, 32'h0);
		rd(can_irq_pkg::FLAG_OFFSET);
		chk("flags reset", d, {2'h0, can_irq_pkg::FLAG_RESET});
		chk("line reset", {30'h0, irq_line}, 32'h0);
		chk("sink reset", {30'h0, pending}, 32'h0);
		summarize();
	end
endmodule
